// [src/sfpi_regs.svh]
// constants for the serial flash pin interface: field positions, counts, idle values
`ifndef SFPI_REGS_SVH
`define SFPI_REGS_SVH
`define SFPI_INSTR_BITS 6'h08
`define SFPI_ADDR_BITS 6'h18
`define SFPI_BYTE_BITS 4'h8
`define SFPI_POS_CS 5
`define SFPI_POS_SCK 4
`define SFPI_POS_WP 2
`define SFPI_POS_HOLD 3
`define SFPI_SYNC_IDLE 6'h3F
`define SFPI_KIND_INSTR 2'h1
`define SFPI_KIND_ADDR 2'h2
`define SFPI_KIND_DATA 2'h3
`define SFPI_FILL_BYTE 8'hFF
`define SFPI_RX_W 10
`define SFPI_BUF_D 2
`endif

// [src/sfpi_pkg.sv]
// types and lane helpers of the serial flash pin interface
package sfpi_pkg;
   typedef enum logic [2:0] {PH_IDLE, PH_INSTR, PH_CFG, PH_ADDR, PH_DUMMY, PH_IN, PH_OUT} sfpi_phase_e;
   typedef enum logic [1:0] {W_ONE, W_TWO, W_FOUR} sfpi_width_e;

   typedef struct packed {
      sfpi_phase_e phase;
      logic armed;
      logic hold;
      logic sck_d;
      logic cs_d;
      sfpi_width_e in_w;
      sfpi_width_e out_w;
      logic [3:0] dummy;
      logic read;
      logic [5:0] cnt;
      logic [2:0] cyc;
      logic [7:0] sh_in;
      logic [3:0] nin;
      logic [7:0] sh_out;
      logic [3:0] nout;
      logic drv;
      logic [3:0] io;
      logic [3:0] oe;
      logic push;
      logic [9:0] push_data;
      logic done;
      logic reject;
      logic take;
      logic overrun;
      logic lock;
      logic standby;
      logic active;
   } sfpi_state_s;

   // bits moved per clock for a lane width
   function automatic logic [3:0] sfpi_lanes(input sfpi_width_e w);
      case (w)
         W_ONE: sfpi_lanes = 4'h1;
         W_TWO: sfpi_lanes = 4'h2;
         default: sfpi_lanes = 4'h4;
      endcase
   endfunction : sfpi_lanes

   // lanes the device drives; single width returns on lane 1 only
   function automatic logic [3:0] sfpi_oe_mask(input sfpi_width_e w);
      case (w)
         W_ONE: sfpi_oe_mask = 4'h2;
         W_TWO: sfpi_oe_mask = 4'h3;
         default: sfpi_oe_mask = 4'hF;
      endcase
   endfunction : sfpi_oe_mask

   // msb first; inside a group the lowest bit sits on lane 0
   function automatic logic [7:0] sfpi_sample(input sfpi_width_e w, input logic [3:0] io,
                                              input logic [7:0] sh);
      case (w)
         W_ONE: sfpi_sample = {sh[6:0], io[0]};
         W_TWO: sfpi_sample = {sh[5:0], io[1:0]};
         default: sfpi_sample = {sh[3:0], io};
      endcase
   endfunction : sfpi_sample

   // next lane values from the top of the output shifter
   function automatic logic [3:0] sfpi_drive(input sfpi_width_e w, input logic [7:0] sh);
      case (w)
         W_ONE: sfpi_drive = {2'h0, sh[7], 1'b0};
         W_TWO: sfpi_drive = {2'h0, sh[7:6]};
         default: sfpi_drive = sh[7:4];
      endcase
   endfunction : sfpi_drive

   // phase that follows the address
   function automatic sfpi_phase_e sfpi_after(input logic [3:0] dummy, input logic read);
      if (dummy != 4'h0) begin
         sfpi_after = PH_DUMMY;
      end else if (read) begin
         sfpi_after = PH_OUT;
      end else begin
         sfpi_after = PH_IN;
      end
   endfunction : sfpi_after
endpackage : sfpi_pkg

// [src/sfpi_stream_if.sv]
// byte stream carrier between the pin front end and its buffer
`timescale 1ns/1ps
`include "sfpi_regs.svh"
interface sfpi_stream_if;
   logic valid;
   logic ready;
   logic [`SFPI_RX_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : sfpi_stream_if

// [src/sfpi_sync.sv]
// two-stage synchroniser for chip select, serial clock and the four lanes
`timescale 1ns/1ps
`include "sfpi_regs.svh"
module sfpi_sync (
   input logic mclk_i,
   input logic rst_i,
   input logic [5:0] raw_i,
   output logic [5:0] sync_o
);
   typedef struct packed {
      logic [5:0] ff1;
      logic [5:0] ff2;
   } sfpi_sync_s;
   sfpi_sync_s q;
   sfpi_sync_s next_q;

   // first stage feeds only the second stage
   always_comb begin
      next_q.ff1 = raw_i;
      next_q.ff2 = q.ff1;
   end

   // idle levels: deselected, pulled-up lanes
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= {`SFPI_SYNC_IDLE, `SFPI_SYNC_IDLE};
      end else begin
         q <= next_q;
      end
   end

   assign sync_o = q.ff2;
endmodule : sfpi_sync

// [src/sfpi_buf.sv]
// two-entry shift buffer on the received byte path
`timescale 1ns/1ps
`include "sfpi_regs.svh"
module sfpi_buf #(
   parameter int W = `SFPI_RX_W,
   parameter int D = `SFPI_BUF_D
) (
   input logic mclk_i,
   input logic rst_i,
   sfpi_stream_if.snk in_s,
   sfpi_stream_if.src out_s
);
   localparam int CW = $clog2(D + 1);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [CW-1:0] cnt;
      logic has;
      logic room;
   } sfpi_buf_s;
   sfpi_buf_s q;
   sfpi_buf_s next_q;
   logic pop;
   logic put;

   // head always sits in entry 0 so the output is a plain flop
   always_comb begin
      next_q = q;
      pop = q.has && out_s.ready;
      put = in_s.valid && q.room;
      if (pop) begin
         for (int i = 0; i < D - 1; i++) begin
            next_q.mem[i] = q.mem[i+1];
         end
      end
      if (put) begin
         next_q.mem[pop ? q.cnt - 1'b1 : q.cnt] = in_s.data;
      end
      next_q.cnt = q.cnt + CW'(put) - CW'(pop);
      next_q.has = (next_q.cnt != '0);
      next_q.room = (next_q.cnt != CW'(D));
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{mem: '0, cnt: '0, has: 1'b0, room: 1'b1};
      end else begin
         q <= next_q;
      end
   end

   assign in_s.ready = q.room;
   assign out_s.valid = q.has;
   assign out_s.data = q.mem[0];
endmodule : sfpi_buf

// [src/sfpi_top.sv]
// pin-level front end of a serial flash: lanes, edges, select, hold and protect
`timescale 1ns/1ps
`include "sfpi_regs.svh"
module sfpi_top
   import sfpi_pkg::*;
(
   input logic mclk_i,
   input logic rst_i,
   input logic sck_i,
   input logic cs_n_i,
   input logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_o,
   input logic quad_lane_enable_i,
   input logic protect_mode_hi_i,
   input logic protect_mode_lo_i,
   input logic busy_i,
   input sfpi_width_e cfg_in_w_i,
   input sfpi_width_e cfg_out_w_i,
   input logic cfg_addr_i,
   input logic [3:0] cfg_dummy_i,
   input logic cfg_read_i,
   input logic [7:0] tx_data_i,
   input logic tx_valid_i,
   output logic tx_take_o,
   output logic [`SFPI_RX_W-1:0] rx_data_o,
   output logic rx_valid_o,
   input logic rx_ready_i,
   output logic cmd_done_o,
   output logic cmd_reject_o,
   output logic overrun_o,
   output logic sr_write_lock_o,
   output logic array_lock_o,
   output logic hold_o,
   output logic standby_o,
   output logic active_o
);
   sfpi_state_s q;
   sfpi_state_s next_q;
   logic [5:0] sync;
   logic s_cs;
   logic s_sck;
   logic [3:0] s_io;
   logic hold_n;
   logic rise;
   logic fall;
   logic live;

   sfpi_stream_if rx_in ();
   sfpi_stream_if rx_out ();

   // pins come from the host's domain, so they pass two flops first
   sfpi_sync u_sync (
      .mclk_i (mclk_i),
      .rst_i (rst_i),
      .raw_i ({cs_n_i, sck_i, io_i}),
      .sync_o (sync)
   );

   // absorbs a short stall of the byte consumer
   sfpi_buf u_buf (
      .mclk_i (mclk_i),
      .rst_i (rst_i),
      .in_s (rx_in.snk),
      .out_s (rx_out.src)
   );

   assign s_cs = sync[`SFPI_POS_CS];
   assign s_sck = sync[`SFPI_POS_SCK];
   assign s_io = sync[3:0];
   // edges found from the sampled clock, idle level irrelevant
   assign rise = s_sck && !q.sck_d;
   assign fall = !s_sck && q.sck_d;
   // in quad mode lane 3 carries data and cannot pause the link
   assign hold_n = quad_lane_enable_i | s_io[`SFPI_POS_HOLD];

   always_comb begin
      logic [7:0] sh;
      logic [3:0] left;
      logic [3:0] ln;
      sfpi_width_e w;
      sh = q.sh_out;
      left = q.nout;
      ln = 4'h1;
      w = W_ONE;
      next_q = q;
      next_q.push = 1'b0;
      next_q.done = 1'b0;
      next_q.reject = 1'b0;
      next_q.take = 1'b0;
      next_q.sck_d = s_sck;
      next_q.cs_d = s_cs;

      // enter hold only while the clock is low
      // leave hold only while the clock is low, or at once on deselect
      if (s_cs) begin
         next_q.hold = 1'b0;
      end else if (q.hold) begin
         if (hold_n && !s_sck) begin
            next_q.hold = 1'b0;
         end
      end else if (!hold_n && !s_sck && q.armed) begin
         next_q.hold = 1'b1;
      end
      // clock edges count only while selected and clear of hold on both sides
      live = !q.hold && !next_q.hold && !s_cs;

      if (s_cs && !q.cs_d) begin
         // a command that ends outside the return phase must end after a multiple of eight clocks
         if (q.armed && q.phase != PH_IDLE) begin
            if (q.phase != PH_OUT && q.cyc != 3'h0) begin
               next_q.reject = 1'b1;
            end else begin
               next_q.done = 1'b1;
            end
         end
         next_q.phase = PH_IDLE;
         next_q.drv = 1'b0;
      end else if (!s_cs && q.cs_d) begin
         // the first select edge arms the decoder
         next_q.armed = 1'b1;
         next_q.phase = PH_INSTR;
         next_q.cnt = 6'h00;
         next_q.cyc = 3'h0;
         next_q.nin = 4'h0;
         next_q.nout = 4'h0;
         next_q.drv = 1'b0;
         next_q.overrun = 1'b0;
      end else if (live && rise && q.phase != PH_IDLE) begin
         // one cycle per clock edge pair, modulo a byte
         next_q.cyc = q.cyc + 3'h1;
         w = (q.phase == PH_INSTR) ? W_ONE : q.in_w;
         ln = sfpi_lanes(w);
         if (q.phase == PH_INSTR || q.phase == PH_ADDR || q.phase == PH_IN) begin
            next_q.sh_in = sfpi_sample(w, s_io, q.sh_in);
            next_q.nin = q.nin + ln;
            if (next_q.nin == `SFPI_BYTE_BITS) begin
               next_q.nin = 4'h0;
               next_q.push = 1'b1;
               case (q.phase)
                  PH_INSTR: next_q.push_data = {`SFPI_KIND_INSTR, next_q.sh_in};
                  PH_ADDR: next_q.push_data = {`SFPI_KIND_ADDR, next_q.sh_in};
                  default: next_q.push_data = {`SFPI_KIND_DATA, next_q.sh_in};
               endcase
            end
         end
         case (q.phase)
            PH_INSTR: begin
               next_q.cnt = q.cnt + 6'h01;
               if (next_q.cnt == `SFPI_INSTR_BITS) begin
                  next_q.phase = PH_CFG;
               end
            end
            PH_ADDR: begin
               // 24 address bits in the chosen width
               next_q.cnt = q.cnt + {2'h0, ln};
               if (next_q.cnt == `SFPI_ADDR_BITS) begin
                  next_q.phase = sfpi_after(q.dummy, q.read);
               end
            end
            PH_DUMMY: begin
               next_q.dummy = q.dummy - 4'h1;
               if (q.dummy == 4'h1) begin
                  next_q.phase = q.read ? PH_OUT : PH_IN;
               end
            end
            default: begin
            end
         endcase
      end else if (live && fall && q.phase != PH_IDLE) begin
         if (q.phase == PH_CFG) begin
            // lane widths chosen by the decoded instruction
            next_q.in_w = cfg_in_w_i;
            next_q.out_w = cfg_out_w_i;
            next_q.dummy = cfg_dummy_i;
            next_q.read = cfg_read_i;
            next_q.cnt = 6'h00;
            next_q.nin = 4'h0;
            next_q.phase = cfg_addr_i ? PH_ADDR : sfpi_after(cfg_dummy_i, cfg_read_i);
         end
         // lanes update right after the falling edge
         if (next_q.phase == PH_OUT) begin
            if (q.nout == 4'h0) begin
               sh = tx_valid_i ? tx_data_i : `SFPI_FILL_BYTE;
               left = `SFPI_BYTE_BITS;
               next_q.take = 1'b1;
            end
            ln = sfpi_lanes(next_q.out_w);
            // msb first, lowest group bit on lane 0, single width on lane 1
            next_q.io = sfpi_drive(next_q.out_w, sh);
            next_q.sh_out = sh << ln;
            next_q.nout = left - ln;
            next_q.drv = 1'b1;
         end
      end

      // drive only returning lanes while selected
      // lanes 0 and 1 turn around for dual and quad returns
      if (next_q.drv && next_q.phase == PH_OUT && !next_q.hold && !s_cs) begin
         next_q.oe = sfpi_oe_mask(next_q.out_w);
      end else begin
         next_q.oe = 4'h0;
      end

      // hardware protect, void under quad enable
      next_q.lock = !quad_lane_enable_i && !s_io[`SFPI_POS_WP] && !protect_mode_hi_i
                    && protect_mode_lo_i;
      // busy keeps power up whatever hold does
      next_q.standby = s_cs && !busy_i;
      next_q.active = !s_cs;
      // a refused push is flagged; set beats the clear at select
      if (q.push && !rx_in.ready) begin
         next_q.overrun = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{phase: PH_IDLE, in_w: W_ONE, out_w: W_ONE, sck_d: 1'b1, cs_d: 1'b1,
                standby: 1'b1, default: '0};
      end else begin
         q <= next_q;
      end
   end

   assign rx_in.valid = q.push;
   assign rx_in.data = q.push_data;
   assign rx_out.ready = rx_ready_i;
   assign rx_valid_o = rx_out.valid;
   assign rx_data_o = rx_out.data;
   assign io_o = q.io;
   assign io_oe_o = q.oe;
   assign tx_take_o = q.take;
   assign cmd_done_o = q.done;
   assign cmd_reject_o = q.reject;
   assign overrun_o = q.overrun;
   assign sr_write_lock_o = q.lock;
   assign array_lock_o = q.lock;
   assign hold_o = q.hold;
   assign standby_o = q.standby;
   assign active_o = q.active;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // capture only at a rising edge
   a_capture_on_rise: assert property ($changed(q.sh_in) |-> $past(rise))
      else $error("input shifter moved without a rising edge");
   // drive only after a falling edge
   a_drive_on_fall: assert property ($changed(io_o) |-> $past(fall))
      else $error("lane value changed without a falling edge");
   a_deselect_float: assert property (s_cs |=> io_oe_o == 4'h0)
      else $error("lane driven while deselected");
   a_standby_power: assert property (s_cs && !busy_i |=> standby_o && !active_o)
      else $error("standby missing while idle and deselected");
   // no decode before the first select edge
   a_unarmed_idle: assert property (!q.armed |-> q.phase == PH_IDLE && !rx_valid_o)
      else $error("decoding before first select edge");
   // single width returns on lane 1 only
   a_single_lane: assert property (io_oe_o != 4'h0 && q.out_w == W_ONE |-> io_oe_o == 4'h2)
      else $error("single width return on wrong lane");
   // lock only under the protect condition
   a_wp_lock: assert property (sr_write_lock_o |-> $past(!s_io[2] && protect_mode_lo_i
      && !protect_mode_hi_i))
      else $error("status write lock without protect condition");
   a_quad_no_lock: assert property (quad_lane_enable_i ##1 quad_lane_enable_i |-> !sr_write_lock_o)
      else $error("lock held under quad enable");
   a_hold_enter: assert property (!q.hold && !hold_n && !s_sck && !s_cs && q.armed
      |=> q.hold && hold_o)
      else $error("hold not entered with clock low");
   a_hold_leave: assert property (q.hold && hold_n && !s_sck |=> !hold_o)
      else $error("hold not left with clock low");
   // hold floats lanes and freezes the sequencer
   a_hold_frozen: assert property (q.hold && $past(q.hold) |-> io_oe_o == 4'h0
      && $stable(q.cyc) && $stable(q.sh_in) && $stable(q.nout))
      else $error("state moved or lanes driven during hold");
   // a clock count not a multiple of eight rejects a command ending outside the return phase
   a_reject_odd: assert property (s_cs && !q.cs_d && q.armed && q.phase != PH_IDLE
      && q.phase != PH_OUT && q.cyc != 3'h0 |=> cmd_reject_o && !cmd_done_o)
      else $error("misaligned command not rejected");
   // drivers only in the return phase
   a_oe_data_only: assert property (io_oe_o != 4'h0 |-> q.phase == PH_OUT && $past(!s_cs))
      else $error("lane driven outside data return");

   c_hold_cycle: cover property (q.hold ##1 !q.hold);
   c_quad_return: cover property (io_oe_o == 4'hF);
   c_reject: cover property (cmd_reject_o);
   c_overrun: cover property (overrun_o);
endmodule : sfpi_top

// [bench/sfpi_host_model.sv]
// host-side serial master model: select, serial clock and lane drive
`timescale 1ns/1ps
module sfpi_host_model (
   input wire logic mclk_i,
   input wire logic [3:0] dev_io_i,
   input wire logic [3:0] dev_oe_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic [3:0] io_o
);
   logic [3:0] hval = 4'h0;
   logic [3:0] hoe = 4'h0;
   logic [3:0] last = 4'h0;
   logic idle_hi = 1'b0;

   // select released and clock parked low before the first frame
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
   end

   // lanes 2 and 3 are pulled up; a floating lane 0 or 1 toggles so no stale value survives
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io_o[i] = dev_oe_i[i] ? dev_io_i[i] : hoe[i] ? hval[i] : (i > 1) ? 1'b1 : ~last[i];
      end
   end

   // remember the resolved level of every lane
   always @(posedge mclk_i) begin
      last <= io_o;
   end

   // half a link clock period is four system clocks
   task automatic half();
      repeat (4) @(posedge mclk_i);
   endtask : half

   // select falls with the clock at its idle level
   task automatic begin_frame(input logic mode3);
      @(posedge mclk_i);
      idle_hi <= mode3;
      sck_o <= mode3;
      half();
      cs_n_o <= 1'b0;
      half();
      half();
   endtask : begin_frame

   // lanes change after the fall, read lanes taken late in the high phase
   task automatic cycle(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
      sck_o <= 1'b0;
      hval <= v;
      hoe <= oe;
      half();
      sck_o <= 1'b1;
      half();
      got = io_o;
   endtask : cycle

   // msb first, lowest group bit on lane 0, single return on lane 1
   task automatic shift(input int n, input int w, input logic [31:0] tx, input logic drive,
                        output logic [31:0] rx);
      logic [3:0] g;
      logic [3:0] m;
      m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
      rx = 32'h0;
      for (int k = n - 1; k >= 0; k--) begin
         cycle(4'((tx >> (k * w)) & 32'(m)), drive ? m : 4'h0, g);
         rx = (rx << w) | ((w == 1) ? 32'(g[1]) : 32'(g & m));
      end
   endtask : shift

   // close a frame; mode 0 parks the clock low first
   task automatic end_frame();
      hoe <= 4'h0;
      if (!idle_hi) begin
         sck_o <= 1'b0;
      end
      half();
      cs_n_o <= 1'b1;
      half();
      half();
   endtask : end_frame

   // single pin drive, used for the protect and hold pins
   task automatic pin(input int i, input logic v, input logic en);
      hval[i] <= v;
      hoe[i] <= en;
   endtask : pin

   task automatic sck_set(input logic v);
      sck_o <= v;
   endtask : sck_set
endmodule : sfpi_host_model

// [bench/sfpi_top_tb.sv]
// self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`include "sfpi_regs.svh"
module sfpi_top_tb
   import sfpi_pkg::*;
;
   logic mclk, rst, busy, qe, pm_hi, pm_lo, cfg_addr, cfg_read, tx_valid, rx_ready;
   logic sck, cs_n, tx_take, rx_valid, done, reject, overrun, wlock, alock, hold;
   logic standby, active;
   logic [3:0] io_in, io_out, io_oe, cfg_dummy;
   logic [7:0] tx_data;
   logic [9:0] rx_data;
   logic [9:0] rxq[$];
   logic [31:0] got;
   sfpi_width_e cfg_in_w, cfg_out_w;
   int err_count = 0;
   int samples_checked = 0;
   int done_cnt = 0;
   int rej_cnt = 0;
   int clash = 0;
   int take_cnt = 0;

   sfpi_top u_dut (.mclk_i(mclk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_in),
      .io_o(io_out), .io_oe_o(io_oe), .quad_lane_enable_i(qe), .protect_mode_hi_i(pm_hi),
      .protect_mode_lo_i(pm_lo), .busy_i(busy), .cfg_in_w_i(cfg_in_w),
      .cfg_out_w_i(cfg_out_w), .cfg_addr_i(cfg_addr), .cfg_dummy_i(cfg_dummy),
      .cfg_read_i(cfg_read), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_take_o(tx_take),
      .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .cmd_done_o(done),
      .cmd_reject_o(reject), .overrun_o(overrun), .sr_write_lock_o(wlock),
      .array_lock_o(alock), .hold_o(hold), .standby_o(standby), .active_o(active));

   sfpi_host_model u_host (.mclk_i(mclk), .dev_io_i(io_out), .dev_oe_i(io_oe), .sck_o(sck),
      .cs_n_o(cs_n), .io_o(io_in));

   // system clock, 100 ns period
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // collect received bytes, pulses and drive clashes on the lanes
   always @(posedge mclk) begin
      if (rx_valid && rx_ready) rxq.push_back(rx_data);
      if (done) done_cnt++;
      if (reject) rej_cnt++;
      if (tx_take) take_cnt++;
      if ((io_oe & u_host.hoe) != 4'h0) clash++;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic setup(input sfpi_width_e iw, input sfpi_width_e ow, input logic a,
                        input logic rd, input logic [3:0] dm, input logic [7:0] tx);
      @(posedge mclk);
      cfg_in_w <= iw;
      cfg_out_w <= ow;
      cfg_addr <= a;
      cfg_read <= rd;
      cfg_dummy <= dm;
      tx_data <= tx;
      rxq.delete();
   endtask : setup

   // single, dual and quad output reads straight after the instruction, modes alternating
   task automatic t_reads();
      sfpi_width_e wl[3] = '{W_ONE, W_TWO, W_FOUR};
      int nl[3] = '{1, 2, 4};
      logic [3:0] ml[3] = '{4'h2, 4'h3, 4'hF};
      int d0;
      for (int k = 0; k < 3; k++) begin
         setup(W_ONE, wl[k], 1'b0, 1'b1, 4'h0, 8'h5A + 8'(k));
         tx_valid <= (k != 1); // the dual read runs dry and must return the fill byte
         d0 = done_cnt;
         u_host.begin_frame(k[0]);
         check("active", 2'b01, {standby, active});
         u_host.shift(8, 1, 32'h6B, 1'b1, got);
         u_host.shift(8 / nl[k], nl[k], 0, 1'b0, got);
         check("read oe", ml[k], io_oe);
         check("read data", (k == 1) ? `SFPI_FILL_BYTE : 8'h5A + 8'(k), got);
         u_host.end_frame();
         check("instr byte", {`SFPI_KIND_INSTR, 8'h6B}, rxq[0]);
         check("done", d0 + 1, done_cnt);
         check("oe idle", 0, io_oe);
      end
      tx_valid <= 1'b1;
      $display("reads finished");
   endtask : t_reads

   // dual io write: address and data in pairs, 24 clocks in all
   task automatic t_dual_write();
      int d0 = done_cnt;
      setup(W_TWO, W_TWO, 1'b1, 1'b0, 4'h0, 8'h00);
      u_host.begin_frame(1'b0);
      u_host.shift(8, 1, 32'h02, 1'b1, got);
      u_host.shift(12, 2, 32'h123456, 1'b1, got);
      u_host.shift(4, 2, 32'h9A, 1'b1, got);
      u_host.end_frame();
      check("rx count", 5, rxq.size());
      check("addr hi", {`SFPI_KIND_ADDR, 8'h12}, rxq[1]);
      check("addr lo", {`SFPI_KIND_ADDR, 8'h56}, rxq[3]);
      check("wr data", {`SFPI_KIND_DATA, 8'h9A}, rxq[4]);
      check("done", d0 + 1, done_cnt);
      check("clash", 0, clash);
      $display("dual write finished");
   endtask : t_dual_write

   // quad io read with latency while the receiver stalls past the buffer depth
   task automatic t_quad_stall();
      int t0 = take_cnt;
      setup(W_FOUR, W_FOUR, 1'b1, 1'b1, 4'h2, 8'hC5);
      rx_ready <= 1'b0;
      u_host.begin_frame(1'b1);
      u_host.shift(8, 1, 32'hEB, 1'b1, got);
      u_host.shift(6, 4, 32'hA1B2C3, 1'b1, got);
      u_host.shift(2, 4, 0, 1'b0, got);
      u_host.shift(2, 4, 0, 1'b0, got);
      check("quad data", 8'hC5, got);
      check("overrun", 2'b11, {overrun, rx_valid});
      u_host.end_frame();
      check("take", t0 + 1, take_cnt);
      rx_ready <= 1'b1;
      repeat (8) @(posedge mclk);
      check("kept", 2, rxq.size());
      check("kept head", {`SFPI_KIND_INSTR, 8'hEB, `SFPI_KIND_ADDR, 8'hA1}, {rxq[0], rxq[1]});
      check("drained", 0, rx_valid);
      $display("quad stall finished");
   endtask : t_quad_stall

   // eleven clocks on a command without data
   task automatic t_reject();
      int r0 = rej_cnt;
      int d0 = done_cnt;
      setup(W_ONE, W_ONE, 1'b0, 1'b0, 4'h0, 8'h00);
      u_host.begin_frame(1'b0);
      u_host.shift(11, 1, 32'h033, 1'b1, got);
      u_host.end_frame();
      check("reject", r0 + 1, rej_cnt);
      check("no done", d0, done_cnt);
      $display("reject finished");
   endtask : t_reject

   // protect pin against the protect mode and quad lane enable, then power state with busy
   task automatic t_protect();
      // each entry: protect pin, quad enable, protect mode hi, protect mode lo
      logic [3:0] pv[5] = '{4'b0001, 4'b1001, 4'b0000, 4'b0101, 4'b0011};
      logic [1:0] ex[5] = '{2'b11, 2'b00, 2'b00, 2'b00, 2'b00};
      @(posedge mclk);
      qe <= 1'b0;
      u_host.begin_frame(1'b0);
      for (int k = 0; k < 5; k++) begin
         {qe, pm_hi, pm_lo} <= pv[k][2:0];
         u_host.pin(2, pv[k][3], 1'b1);
         repeat (8) @(posedge mclk);
         check("locks", ex[k], {wlock, alock});
      end
      u_host.pin(2, 1'b1, 1'b0);
      u_host.end_frame();
      busy <= 1'b1;
      repeat (8) @(posedge mclk);
      check("busy power", 2'b00, {standby, active});
      busy <= 1'b0;
      repeat (8) @(posedge mclk);
      check("standby", 2'b10, {standby, active});
      $display("protect finished");
   endtask : t_protect

   // hold asserted and released with the clock high, clocks and lane 0 toggled meanwhile
   task automatic t_hold();
      int d0 = done_cnt;
      setup(W_ONE, W_ONE, 1'b0, 1'b0, 4'h0, 8'h00);
      qe <= 1'b0;
      u_host.begin_frame(1'b0);
      u_host.shift(4, 1, 32'hC, 1'b1, got);
      u_host.pin(3, 1'b0, 1'b1);
      repeat (8) @(posedge mclk);
      check("hold early", 0, hold);
      u_host.sck_set(1'b0);
      repeat (8) @(posedge mclk);
      check("hold on", 2'b10, {hold, io_oe[1]});
      u_host.cycle(4'h1, 4'h9, got);
      u_host.cycle(4'h0, 4'h9, got);
      u_host.pin(3, 1'b1, 1'b1);
      repeat (8) @(posedge mclk);
      check("hold late", 1, hold);
      u_host.sck_set(1'b0);
      repeat (8) @(posedge mclk);
      check("hold off", 0, hold);
      u_host.shift(4, 1, 32'h7, 1'b1, got);
      u_host.end_frame();
      check("frozen", {`SFPI_KIND_INSTR, 8'hC7}, rxq[0]);
      check("done", d0 + 1, done_cnt);
      $display("hold finished");
   endtask : t_hold

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   // main sequence; quad lanes enabled so the hold pin stays out of the way
   initial begin
      {rst, busy, qe, pm_hi, pm_lo, cfg_addr, cfg_read} = 7'b0010000;
      {tx_valid, rx_ready, cfg_dummy, tx_data} = {2'b11, 4'h0, 8'h00};
      {cfg_in_w, cfg_out_w} = {W_ONE, W_ONE};
      rst = 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      check("reset", 4'b1000, {standby, active, hold, rx_valid});
      check("reset oe", 0, io_oe);
      t_reads();
      t_dual_write();
      t_quad_stall();
      t_reject();
      t_protect();
      t_hold();
      print_verdict();
   end

   // watchdog well past the expected run of about 1100 system clocks
   initial begin
      #3000000;
      err_count++;
      $display("[FAIL] watchdog expected finish seen hang");
      print_verdict();
   end
endmodule : sfpi_top_tb
